/* design/rtc_second_long_interval_timer.sv */
// Purpose: Second long-interval timer of the clock unit with the unit's interrupt status register.
// Assumes: The 32.768 kHz clock and the unit reset arrive as pins and are sampled on clk_sys.
// Notes:   Registers are reached over AXI4-Lite; one write and one read may be under way.
//
// Summary of operation
// - Hold 24-bit reload period, upper byte in high register, countdown starts from it.
// - New period takes effect only after both low and high halves are written.
// - A zero period stops the countdown and raises no timer interrupts.
// - Count decrements by one on each 32.768 kHz clock cycle while running.
// - At count one, set the timer flag, reload the period and keep counting.
// - Live count reads directly as low 16 and high 8 bits, no snapshot.
// - Status bit 2 shows this timer's interrupt; writing one clears it.
// - Status bit 1 records the first timer's interrupt; writing one clears it.
// - Status bit 0 records the elapsed counter's interrupt; writing one clears it.
// - Reserved bits of status, period high and count high read zero.
// - Unit reset clears period, count, flags; other resets preserve them.
// - The first timer signals its request at count one, then reloads.
`timescale 1ns/10ps
`default_nettype none
`include "rtc_timer_defines.svh"

// COUNT_WIDTH is fixed by the register map; the check in the body refuses other values.
module rtc_second_long_interval_timer #(
  parameter int unsigned COUNT_WIDTH = 24
) (
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  input  wire logic                   clockUnitReset_n,
  input  wire logic                   rtcClk32k,
  input  wire logic                   firstTimerEvent,
  input  wire logic                   elapsedEvent,
  input  wire rtc_timer_pkg::axi_req_t axiReq,
  output var  rtc_timer_pkg::axi_rsp_t axiRsp,
  output      logic                   secondTimerEvent
);

  // Pin synchronisers.
  logic        rtcClkSync;
  logic        rtcClkPrev_ff;
  logic        unitRstSync_n;
  logic        tick;
  logic        unitRst;

  // Write channel state.
  logic        awHeld_ff;
  logic [31:0] awAddr_ff;
  logic        wHeld_ff;
  logic [31:0] wData_ff;
  logic [3:0]  wStrb_ff;
  logic        bValid_ff;
  logic [1:0]  bResp_ff;
  logic        doWrite;

  // Read channel state.
  logic        rValid_ff;
  logic [31:0] rData_ff;
  logic [1:0]  rResp_ff;
  logic        arTake;
  logic [31:0] nxt_rData;
  logic [1:0]  nxt_rResp;

  // Decoded write targets.
  logic        wrPeriodLow;
  logic        wrPeriodHigh;
  logic        wrCountLow;
  logic        wrCountHigh;
  logic        wrStatus;
  logic        wrMapped;

  // Timer state.
  logic [15:0] stageLow_ff;
  logic [7:0]  stageHigh_ff;
  logic        lowWritten_ff;
  logic        highWritten_ff;
  logic        loadPending_ff;
  logic [COUNT_WIDTH-1:0] period_ff;
  logic [COUNT_WIDTH-1:0] count_ff;
  logic        secondEvent_ff;
  logic [2:0]  irqFlags_ff;
  logic [2:0]  nxt_irqFlags;
  logic [2:0]  setFlags;
  logic [2:0]  clearFlags;

  function automatic logic [31:0] byteAddr(input logic [31:0] idx);
    byteAddr = {idx[29:0], 2'b00};
  endfunction

  // The register map splits the count into a 16-bit and an 8-bit half; no other width is served.
  if (COUNT_WIDTH != 24) begin : g_width_check
    $error("count width must be 24");
  end

  // Both pins pass two flops with no reset: a system reset must neither stall the slow
  // clock nor look like a unit reset, or period, count and flags would be lost.
  rtc_pin_sync u_rtcClkSync (
    .clk_sys  (clk_sys),
    .pinAsync (rtcClk32k),
    .pinSync  (rtcClkSync)
  );

  rtc_pin_sync u_unitRstSync (
    .clk_sys  (clk_sys),
    .pinAsync (clockUnitReset_n),
    .pinSync  (unitRstSync_n)
  );

  // The edge detector has no reset either, so no false tick follows a system reset.
  always_ff @(posedge clk_sys) begin
    rtcClkPrev_ff <= rtcClkSync;
  end

  // One tick per rising edge of the slow clock.
  assign tick    = rtcClkSync & ~rtcClkPrev_ff;
  assign unitRst = ~unitRstSync_n;

  // Write address and data are taken in either order and held until the response.
  // A channel that has been taken stays closed until the response handshake, so a
  // second write can never overtake the first.
  assign doWrite = awHeld_ff & wHeld_ff & ~bValid_ff;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= 32'h00000000;
    end else if (axiReq.awvalid && !awHeld_ff && !bValid_ff) begin
      awHeld_ff <= 1'b1;
      awAddr_ff <= axiReq.awaddr;
    end else if (doWrite) begin
      awHeld_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wHeld_ff <= 1'b0;
      wData_ff <= 32'h00000000;
      wStrb_ff <= 4'h0;
    end else if (axiReq.wvalid && !wHeld_ff && !bValid_ff) begin
      wHeld_ff <= 1'b1;
      wData_ff <= axiReq.wdata;
      wStrb_ff <= axiReq.wstrb;
    end else if (doWrite) begin
      wHeld_ff <= 1'b0;
    end
  end

  always_comb begin
    wrPeriodLow  = awAddr_ff == byteAddr(`PERIOD_LOW_IDX);
    wrPeriodHigh = awAddr_ff == byteAddr(`PERIOD_HIGH_IDX);
    wrCountLow   = awAddr_ff == byteAddr(`COUNT_LOW_IDX);
    wrCountHigh  = awAddr_ff == byteAddr(`COUNT_HIGH_IDX);
    wrStatus     = awAddr_ff == byteAddr(`IRQ_STATUS_IDX);
    wrMapped     = wrPeriodLow | wrPeriodHigh | wrCountLow | wrCountHigh | wrStatus;
  end

  // Writes to the read-only count registers are accepted and ignored.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      bValid_ff <= 1'b0;
      bResp_ff  <= `RESP_OKAY;
    end else if (doWrite) begin
      bValid_ff <= 1'b1;
      bResp_ff  <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (axiReq.bready) begin
      bValid_ff <= 1'b0;
    end
  end

  // Period halves are staged; the pair becomes a pending load only once both are written.
  // A half written twice does not complete a pair; only the other half does.
  // The staged halves read back as written, before they are applied.
  always_ff @(posedge clk_sys) begin
    if (unitRst) begin
      stageLow_ff    <= 16'h0000;
      stageHigh_ff   <= 8'h00;
      lowWritten_ff  <= 1'b0;
      highWritten_ff <= 1'b0;
    end else if (doWrite && wrPeriodLow && wStrb_ff[1:0] != 2'b00) begin
      if (wStrb_ff[0]) stageLow_ff[7:0]  <= wData_ff[7:0];
      if (wStrb_ff[1]) stageLow_ff[15:8] <= wData_ff[15:8];
      if (highWritten_ff) begin
        highWritten_ff <= 1'b0;
      end else begin
        lowWritten_ff <= 1'b1;
      end
    end else if (doWrite && wrPeriodHigh && wStrb_ff[0]) begin
      stageHigh_ff <= wData_ff[7:0];
      if (lowWritten_ff) begin
        lowWritten_ff <= 1'b0;
      end else begin
        highWritten_ff <= 1'b1;
      end
    end
  end

  // The completing half raises the pending load, which the next slow tick consumes.
  // A pair that completes on a tick waits for the following tick, which the
  // spacing that software keeps between settings leaves room for.
  always_ff @(posedge clk_sys) begin
    if (unitRst) begin
      loadPending_ff <= 1'b0;
    end else if (doWrite && ((wrPeriodLow && wStrb_ff[1:0] != 2'b00 && highWritten_ff) ||
                             (wrPeriodHigh && wStrb_ff[0] && lowWritten_ff))) begin
      loadPending_ff <= 1'b1;
    end else if (tick) begin
      loadPending_ff <= 1'b0;
    end
  end

  // Period, count and flags answer only to the unit reset, so reset_n leaves them running.
  always_ff @(posedge clk_sys) begin
    if (unitRst) begin
      period_ff <= `PERIOD_RESET;
    end else if (tick && loadPending_ff) begin
      period_ff <= {stageHigh_ff, stageLow_ff};
    end
  end

  // The count moves only on slow ticks. A zero period freezes it, and a reload at
  // count one restarts the period without help from software.
  always_ff @(posedge clk_sys) begin
    if (unitRst) begin
      count_ff       <= `COUNT_RESET;
      secondEvent_ff <= 1'b0;
    end else begin
      secondEvent_ff <= 1'b0;
      if (tick) begin
        if (loadPending_ff) begin
          count_ff <= {stageHigh_ff, stageLow_ff};
        end else if (period_ff == `PERIOD_RESET) begin
          count_ff <= count_ff;
        end else if (count_ff == `COUNT_TERMINAL) begin
          count_ff       <= period_ff;
          secondEvent_ff <= 1'b1;
        end else begin
          count_ff <= count_ff - 24'h000001;
        end
      end
    end
  end

  assign secondTimerEvent = secondEvent_ff;

  // Sticky flags; a set in the same cycle as a write-one clear wins.
  always_comb begin
    setFlags   = 3'h0;
    clearFlags = 3'h0;
    setFlags[`SECOND_FLAG_BIT]  = secondEvent_ff;
    setFlags[`FIRST_FLAG_BIT]   = firstTimerEvent;
    setFlags[`ELAPSED_FLAG_BIT] = elapsedEvent;
    if (doWrite && wrStatus && wStrb_ff[0]) begin
      clearFlags = wData_ff[2:0];
    end
    nxt_irqFlags = (irqFlags_ff & ~clearFlags) | setFlags;
  end

  // Only the unit reset clears the flags; a system reset leaves pending requests visible.
  always_ff @(posedge clk_sys) begin
    if (unitRst) begin
      irqFlags_ff <= `FLAGS_RESET;
    end else begin
      irqFlags_ff <= nxt_irqFlags;
    end
  end

  // Read path: one beat, answered the cycle after the address is taken.
  // The live count is returned with no snapshot; software compares two reads
  // when it needs a value that is consistent across both halves.
  assign arTake = axiReq.arvalid & ~rValid_ff;

  always_comb begin
    nxt_rResp = `RESP_OKAY;
    nxt_rData = 32'h00000000;
    if (axiReq.araddr == byteAddr(`PERIOD_LOW_IDX)) begin
      nxt_rData[15:0] = stageLow_ff;
    end else if (axiReq.araddr == byteAddr(`PERIOD_HIGH_IDX)) begin
      nxt_rData[7:0] = stageHigh_ff;
    end else if (axiReq.araddr == byteAddr(`COUNT_LOW_IDX)) begin
      nxt_rData[15:0] = count_ff[15:0];
    end else if (axiReq.araddr == byteAddr(`COUNT_HIGH_IDX)) begin
      nxt_rData[7:0] = count_ff[23:16];
    end else if (axiReq.araddr == byteAddr(`IRQ_STATUS_IDX)) begin
      nxt_rData[2:0] = irqFlags_ff;
    end else begin
      nxt_rResp = `RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rValid_ff <= 1'b0;
      rData_ff  <= 32'h00000000;
      rResp_ff  <= `RESP_OKAY;
    end else if (arTake) begin
      rValid_ff <= 1'b1;
      rData_ff  <= nxt_rData;
      rResp_ff  <= nxt_rResp;
    end else if (axiReq.rready) begin
      rValid_ff <= 1'b0;
    end
  end

  // Ready signals are combinational so a channel opens in the same cycle that it frees.
  always_comb begin
    axiRsp.awready = ~awHeld_ff & ~bValid_ff;
    axiRsp.wready  = ~wHeld_ff & ~bValid_ff;
    axiRsp.bvalid  = bValid_ff;
    axiRsp.bresp   = bResp_ff;
    axiRsp.arready = ~rValid_ff;
    axiRsp.rvalid  = rValid_ff;
    axiRsp.rdata   = rData_ff;
    axiRsp.rresp   = rResp_ff;
  end

endmodule // rtc_second_long_interval_timer

// Two-flop synchroniser for a pin from outside the clk_sys domain.
// Only the second flop is seen by the logic that uses the pin.
module rtc_pin_sync (
  input  wire logic clk_sys,
  input  wire logic pinAsync,
  output var  logic pinSync
);

  logic pinMeta_ff;
  logic pinSync_ff;

  always_ff @(posedge clk_sys) begin
    pinMeta_ff <= pinAsync;
    pinSync_ff <= pinMeta_ff;
  end

  assign pinSync = pinSync_ff;

endmodule // rtc_pin_sync
`default_nettype wire

/* design/rtc_timer_defines.svh */
// Purpose: Offsets, field positions and reset values of the second long-interval timer.
// Assumes: Printed offsets are register indices; the byte address is four times the index.
// Notes:   Definitions only.
`ifndef RTC_TIMER_DEFINES_SVH
`define RTC_TIMER_DEFINES_SVH

`define PERIOD_LOW_IDX        32'h0b0000d8
`define PERIOD_HIGH_IDX       32'h0b0000da
`define COUNT_LOW_IDX         32'h0b0000dc
`define COUNT_HIGH_IDX        32'h0b0000de
`define IRQ_STATUS_IDX        32'h0b0001de

`define SECOND_FLAG_BIT       2
`define FIRST_FLAG_BIT        1
`define ELAPSED_FLAG_BIT      0

`define PERIOD_RESET          24'h000000
`define COUNT_RESET           24'h000000
`define FLAGS_RESET           3'h0
`define COUNT_TERMINAL        24'h000001

`define RESP_OKAY             2'h0
`define RESP_SLVERR           2'h2

`endif

/* design/rtc_timer_pkg.sv */
// Purpose: Types shared by the second long-interval timer and its bench.
// Assumes: AXI4-Lite with 32-bit address and data.
// Notes:   Channel signals travel as packed structs.
package rtc_timer_pkg;

  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axi_rsp_t;

endpackage

/* verif/rtc_second_long_interval_timer_sva.sv */
// Purpose: Port-level checks of bus handshakes and timer events.
// Assumes: One clk_sys domain with reset_n synchronous and active low.
// Notes:   Bound to every instance of the timer.
`timescale 1ns/10ps
`default_nettype none
`include "rtc_timer_defines.svh"
module rtc_second_long_interval_timer_sva (
  input wire logic                    clk_sys,
  input wire logic                    reset_n,
  input wire logic                    clockUnitReset_n,
  input wire logic                    rtcClk32k,
  input wire logic                    firstTimerEvent,
  input wire logic                    elapsedEvent,
  input wire rtc_timer_pkg::axi_req_t axiReq,
  input wire rtc_timer_pkg::axi_rsp_t axiRsp,
  input wire logic                    secondTimerEvent
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence sRdTake;
    axiReq.arvalid && axiRsp.arready;
  endsequence
  sequence sWrBoth;
    axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
  endsequence
  a_read_answer: assert property (sRdTake |=> axiRsp.rvalid)
    else $error("read answer missing");
  a_write_answer: assert property (sWrBoth |-> ##[1:2] axiRsp.bvalid)
    else $error("write answer missing");
  a_rdata_hold: assert property (axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata))
    else $error("read data not held");
  a_bresp_hold: assert property (axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp))
    else $error("write response not held");
  a_ar_refused: assert property (axiRsp.rvalid |-> !axiRsp.arready)
    else $error("read taken while answer pending");
  a_aw_refused: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
    else $error("write taken while answer pending");
  a_event_pulse: assert property (secondTimerEvent |=> !secondTimerEvent)
    else $error("timer event longer than one cycle");
  a_unit_quiet: assert property (!clockUnitReset_n [*5] |-> !secondTimerEvent)
    else $error("timer event during unit reset");
  a_resp_code: assert property (axiRsp.rvalid |-> axiRsp.rresp inside {`RESP_OKAY, `RESP_SLVERR})
    else $error("bad read response code");
endmodule // rtc_second_long_interval_timer_sva
bind rtc_second_long_interval_timer rtc_second_long_interval_timer_sva u_sva (.clk_sys, .reset_n,
  .clockUnitReset_n, .rtcClk32k, .firstTimerEvent, .elapsedEvent, .axiReq, .axiRsp, .secondTimerEvent);
`default_nettype wire

/* verif/rtc_second_long_interval_timer_tb.sv */
// Purpose: Self-checking bench of the second long-interval timer.
// Assumes: The slow clock pin is pulsed by hand, far faster than 32.768 kHz, to keep the run short.
// Notes:   Each scenario is a task that judges its own results.
`timescale 1ns/10ps
`default_nettype none
`include "rtc_timer_defines.svh"
module rtc_second_long_interval_timer_tb;
  localparam logic [31:0] adrPerLo = `PERIOD_LOW_IDX * 4;
  localparam logic [31:0] adrPerHi = `PERIOD_HIGH_IDX * 4;
  localparam logic [31:0] adrCntLo = `COUNT_LOW_IDX * 4;
  localparam logic [31:0] adrCntHi = `COUNT_HIGH_IDX * 4;
  localparam logic [31:0] adrIrq   = `IRQ_STATUS_IDX * 4;
  logic                    clk_sys, reset_n, unitRst_n, rtcClk, firstEv, elapsedEv, secondEv;
  rtc_timer_pkg::axi_req_t req;
  rtc_timer_pkg::axi_rsp_t rsp;
  logic [31:0]             rd;
  logic [1:0]              rs;
  int                      failures, n_checks;
  int                      nEvents = 0;
  rtc_second_long_interval_timer u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .clockUnitReset_n(unitRst_n),
    .rtcClk32k(rtcClk), .firstTimerEvent(firstEv), .elapsedEvent(elapsedEv), .axiReq(req), .axiRsp(rsp),
    .secondTimerEvent(secondEv));
  always @(posedge clk_sys) if (secondEv === 1'b1) nEvents <= nEvents + 1;
  task automatic tally_and_finish();
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hang();
    failures++;
    $display("[FAIL] bus answer expected 1 seen 0");
    tally_and_finish();
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_sys);
      if (rsp.awready === 1'b1 && req.awvalid) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1 && req.wvalid) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) break;
    end
    if (n == 100) hang();
    rs = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic rdr(input logic [31:0] a);
    int n;
    @(posedge clk_sys);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_sys);
      if (rsp.arready === 1'b1 && req.arvalid) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) break;
    end
    if (n == 100) hang();
    rd = rsp.rdata;
    rs = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  task automatic expRd(input string nm, input logic [31:0] a, input logic [31:0] e);
    rdr(a);
    chk(nm, e, rd);
  endtask
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clk_sys) rtcClk <= 1'b1;
      repeat (8) @(posedge clk_sys);
      rtcClk <= 1'b0;
      repeat (8) @(posedge clk_sys);
    end
  endtask
  task automatic pulse(input logic first);
    @(posedge clk_sys) if (first) firstEv <= 1'b1; else elapsedEv <= 1'b1;
    @(posedge clk_sys) {firstEv, elapsedEv} <= 2'b00;
  endtask
  task automatic tReset();
    expRd("period low", adrPerLo, 32'h0);
    expRd("period high", adrPerHi, 32'h0);
    expRd("count low", adrCntLo, 32'h0);
    expRd("irq status", adrIrq, 32'h0);
  endtask
  task automatic tPair();
    wr(adrPerLo, 32'h0000_0006);
    tick(1);
    expRd("count one half", adrCntLo, 32'h0);
    wr(adrPerHi, 32'hffff_ff01);
    expRd("period high", adrPerHi, 32'h1);
    tick(1);
    expRd("count high", adrCntHi, 32'h1);
    expRd("count low", adrCntLo, 32'h6);
    tick(1);
    rdr(adrCntLo);
    expRd("count twice", adrCntLo, rd);
    chk("count step", 32'h5, rd);
  endtask
  task automatic tReload();
    int i;
    tick(1);
    wr(adrPerHi, 32'h0);
    wr(adrPerLo, 32'h6);
    tick(1);
    for (i = 5; i >= 1; i--) begin
      tick(1);
      expRd("count down", adrCntLo, i);
    end
    expRd("flag idle", adrIrq, 32'h0);
    tick(1);
    expRd("count reload", adrCntLo, 32'h6);
    expRd("flag set", adrIrq, 32'h4);
    chk("event count", 32'h1, nEvents);
    wr(adrIrq, 32'h4);
    expRd("flag clear", adrIrq, 32'h0);
  endtask
  task automatic tFlags();
    pulse(1'b1);
    pulse(1'b0);
    expRd("both flags", adrIrq, 32'h3);
    wr(adrIrq, 32'hffff_fff9);
    expRd("one flag left", adrIrq, 32'h2);
    fork
      wr(adrIrq, 32'h2);
      begin
        @(posedge clk_sys);
        pulse(1'b1);
      end
    join
    expRd("set wins", adrIrq, 32'h2);
    wr(adrIrq, 32'h2);
    expRd("flags clear", adrIrq, 32'h0);
    wr(adrCntLo, 32'h1234);
    chk("count write resp", `RESP_OKAY, rs);
    wr(32'h0000_0100, 32'h1);
    chk("unmapped write", `RESP_SLVERR, rs);
    rdr(32'h0000_0104);
    chk("unmapped read", `RESP_SLVERR, rs);
  endtask
  task automatic tZero();
    wr(adrPerLo, 32'h0);
    wr(adrPerHi, 32'h0);
    tick(1);
    expRd("count zero", adrCntLo, 32'h0);
    tick(3);
    expRd("count stopped", adrCntLo, 32'h0);
    chk("no new event", 32'h1, nEvents);
  endtask
  task automatic tSysRst();
    wr(adrPerLo, 32'h8);
    wr(adrPerHi, 32'h0);
    tick(1);
    pulse(1'b0);
    @(posedge clk_sys) reset_n <= 1'b0;
    tick(1);
    @(posedge clk_sys) reset_n <= 1'b1;
    expRd("period kept", adrPerLo, 32'h8);
    expRd("count runs", adrCntLo, 32'h7);
    expRd("flag kept", adrIrq, 32'h1);
    tick(1);
    expRd("count after reset", adrCntLo, 32'h6);
  endtask
  task automatic tUnitRst();
    wr(adrPerLo, 32'h9);
    wr(adrPerHi, 32'h0);
    tick(1);
    pulse(1'b1);
    expRd("count before", adrCntLo, 32'h9);
    @(posedge clk_sys) unitRst_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    unitRst_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    tReset();
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    req = '0;
    {reset_n, unitRst_n, rtcClk, firstEv, elapsedEv} = 5'h00;
    failures = 0;
    n_checks = 0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    unitRst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    tReset();
    tPair();
    tReload();
    tFlags();
    tZero();
    tSysRst();
    tUnitRst();
    tally_and_finish();
  end
endmodule // rtc_second_long_interval_timer_tb
`default_nettype wire
